// [rtl/i2c_master_engine.sv]
// Master engine of a two-wire port: transmit, receive, ack, stop, collision
`timescale 1ns/1ns
// What this block does
// - Buffer write sets buffer_full; cleared after eight bits shift out.
// - Buffer write while busy is dropped and sets write_collision.
// - Ninth-bit ack low clears ack status, high sets it.
// - Receive enable starts reception only from idle, else ignored.
// - Reception toggles SCL each counter rollover, shifting SDA in.
// - After eighth fall: clear enable, load buffer, set flags, hold SCL.
// - Reading the buffer in receive clears buffer_full.
// - Byte received while buffer_full set raises receive_overflow.
// - Ack sequence: SCL low, drive ack bit, low period, high period.
// - Stop: SDA low, then release SCL, then SDA one period later.
// - SDA high with SCL high sets halt; period later event, clear.
// - Released SCL pauses counter until seen high, then reloads.
// - Port keeps working in sleep and wakes on completed byte.
// - Reset disables the port and aborts any transfer.
// - Released SDA seen low while SCL high in a sent data bit, ack sequence or stop is a collision.
// - Data collision stops shifting, clears buffer_full, frees lines.
// - Condition collision aborts it and clears its enable bits.
// - After collision, bus STOP detection sets port_event_flag.
// - New byte after collision starts at its first bit.
// - Counter loads low seven reload bits, counts to zero, stops.
// - Counter steps twice per instruction cycle.
module i2c_master_engine (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             wake_req
);
  typedef enum {ST_IDLE, ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
                ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_SDA, ST_STOP_LOW,
                ST_STOP_HIGH, ST_STOP_END} state_t;

  state_t     state_reg;
  logic [7:0] data_buffer_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] rate_reload_reg;
  logic       port_en_reg;
  logic       buffer_full, write_collision, receive_overflow;
  logic       ack_received_status, ack_value_bit, ack_sequence_enable;
  logic       receive_enable_bit, stop_sequence_enable;
  logic       halt_detected, begin_detected;
  logic       port_event_flag, collision_flag, event_ie_reg, coll_ie_reg;
  logic       rx_mode_reg, scl_drive_low, sda_drive_low, scl_seen_high;
  logic       scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
  logic       wr, rd, busy, collide, byte_done_tx, byte_done_rx;
  logic       bus_start, bus_stop, stop_done, ack_done;
  logic       wr_data, wr_ctl, wr_evt;
  rate_if     rif ();

  rate_counter u_rate (.clk(clk), .rst_n(rst_n), .rif(rif));

  // Two-flop synchronisers on the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      scl_d  <= scl_s2;
      sda_d  <= sda_s2;
    end
  end

  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop  = scl_s2 && scl_d && !sda_d && sda_s2;

  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign wr_data = wr && paddr == i2c_master_pkg::DATA_BUFFER_OFF;
  assign wr_ctl  = wr && paddr == i2c_master_pkg::CONTROL2_OFF;
  assign wr_evt  = wr && paddr == i2c_master_pkg::EVENT_OFF;
  assign busy    = state_reg != ST_IDLE || ack_sequence_enable ||
                   stop_sequence_enable;
  assign scl_seen_high = scl_s2;

  // Released SDA pulled low while SCL high
  assign collide = port_en_reg && !sda_drive_low && scl_s2 && !sda_s2 &&
                   ((state_reg == ST_TX_HIGH && bit_cnt_reg != 4'd8) ||
                    state_reg == ST_ACK_HIGH ||
                    state_reg == ST_STOP_END);
  assign byte_done_tx = state_reg == ST_TX_HIGH && rif.timeout &&
                        bit_cnt_reg == 4'd8;
  assign byte_done_rx = state_reg == ST_RX_HIGH && rif.timeout &&
                        bit_cnt_reg == 4'd7;
  assign ack_done  = state_reg == ST_ACK_HIGH && rif.timeout;
  assign stop_done = state_reg == ST_STOP_END && rif.timeout;

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        i2c_master_pkg::DATA_BUFFER_OFF: prdata[7:0] = data_buffer_reg;
        i2c_master_pkg::STATUS_OFF: begin
          prdata[i2c_master_pkg::BUFFER_FULL_BIT]   = buffer_full;
          prdata[i2c_master_pkg::START_SEEN_BIT]    = begin_detected;
          prdata[i2c_master_pkg::HALT_DETECTED_BIT] = halt_detected;
          prdata[i2c_master_pkg::RX_OVERFLOW_BIT]   = receive_overflow;
          prdata[i2c_master_pkg::WRITE_COLL_BIT]    = write_collision;
        end
        i2c_master_pkg::CONTROL2_OFF: begin
          prdata[i2c_master_pkg::PORT_ENABLE_BIT] = port_en_reg;
          prdata[i2c_master_pkg::ACK_STATUS_BIT]  = ack_received_status;
          prdata[i2c_master_pkg::ACK_VALUE_BIT]   = ack_value_bit;
          prdata[i2c_master_pkg::ACK_SEQ_BIT]     = ack_sequence_enable;
          prdata[i2c_master_pkg::RX_ENABLE_BIT]   = receive_enable_bit;
          prdata[i2c_master_pkg::STOP_SEQ_BIT]    = stop_sequence_enable;
        end
        i2c_master_pkg::RATE_RELOAD_OFF: prdata[6:0] = rate_reload_reg;
        i2c_master_pkg::EVENT_OFF: begin
          prdata[i2c_master_pkg::PORT_EVENT_BIT]   = port_event_flag;
          prdata[i2c_master_pkg::COLLISION_BIT]    = collision_flag;
          prdata[i2c_master_pkg::EVENT_IE_BIT]     = event_ie_reg;
          prdata[i2c_master_pkg::COLLISION_IE_BIT] = coll_ie_reg;
        end
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Reset disables the port; clearing enable aborts too
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_en_reg     <= 1'b0;
      rate_reload_reg <= i2c_master_pkg::RATE_RELOAD_RST;
      ack_value_bit   <= 1'b0;
      event_ie_reg    <= 1'b0;
      coll_ie_reg     <= 1'b0;
    end else begin
      if (wr_ctl) begin
        port_en_reg   <= pwdata[i2c_master_pkg::PORT_ENABLE_BIT];
        ack_value_bit <= pwdata[i2c_master_pkg::ACK_VALUE_BIT];
      end
      if (wr && paddr == i2c_master_pkg::RATE_RELOAD_OFF) begin
        rate_reload_reg <= pwdata[6:0];
      end
      if (wr_evt) begin
        event_ie_reg <= pwdata[i2c_master_pkg::EVENT_IE_BIT];
        coll_ie_reg  <= pwdata[i2c_master_pkg::COLLISION_IE_BIT];
      end
    end
  end

  // Enable bits: set by software only from idle, cleared by hardware
  always_ff @(posedge clk) begin
    if (!rst_n || !port_en_reg) begin
      receive_enable_bit   <= 1'b0;
      ack_sequence_enable  <= 1'b0;
      stop_sequence_enable <= 1'b0;
    end else if (collide) begin
      ack_sequence_enable  <= 1'b0;
      stop_sequence_enable <= 1'b0;
      receive_enable_bit   <= 1'b0;
    end else if (wr_ctl && !busy && !receive_enable_bit) begin
      receive_enable_bit   <= pwdata[i2c_master_pkg::RX_ENABLE_BIT];
      ack_sequence_enable  <= pwdata[i2c_master_pkg::ACK_SEQ_BIT];
      stop_sequence_enable <= pwdata[i2c_master_pkg::STOP_SEQ_BIT];
    end else begin
      if (byte_done_rx) begin
        receive_enable_bit <= 1'b0;
      end
      if (ack_done) begin
        ack_sequence_enable <= 1'b0;
      end
      if (stop_done) begin
        stop_sequence_enable <= 1'b0;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n || !port_en_reg) begin
      state_reg     <= ST_IDLE;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
      bit_cnt_reg   <= 4'd0;
      rx_mode_reg   <= 1'b0;
      shift_reg     <= 8'h00;
    end else if (collide) begin
      state_reg     <= ST_IDLE;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
      bit_cnt_reg   <= 4'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_data && !busy) begin
            shift_reg     <= pwdata[7:0];
            bit_cnt_reg   <= 4'd0;
            rx_mode_reg   <= 1'b0;
            scl_drive_low <= 1'b1;
            sda_drive_low <= !pwdata[7];
            state_reg     <= ST_TX_LOW;
          end else if (wr_ctl && !busy &&
                       pwdata[i2c_master_pkg::RX_ENABLE_BIT]) begin
            rx_mode_reg   <= 1'b1;
            bit_cnt_reg   <= 4'd0;
            scl_drive_low <= 1'b1;
            sda_drive_low <= 1'b0;
            state_reg     <= ST_RX_LOW;
          end else if (wr_ctl && !busy &&
                       pwdata[i2c_master_pkg::ACK_SEQ_BIT]) begin
            scl_drive_low <= 1'b1;
            sda_drive_low <= !pwdata[i2c_master_pkg::ACK_VALUE_BIT];
            state_reg     <= ST_ACK_LOW;
          end else if (wr_ctl && !busy &&
                       pwdata[i2c_master_pkg::STOP_SEQ_BIT]) begin
            sda_drive_low <= 1'b1;
            state_reg     <= ST_STOP_SDA;
          end
        end
        ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW, ST_STOP_LOW: begin
          if (rif.timeout) begin
            scl_drive_low <= 1'b0;
            case (state_reg)
              ST_TX_LOW:  state_reg <= ST_TX_HIGH;
              ST_RX_LOW:  state_reg <= ST_RX_HIGH;
              ST_ACK_LOW: state_reg <= ST_ACK_HIGH;
              default:    state_reg <= ST_STOP_HIGH;
            endcase
          end
        end
        ST_TX_HIGH: begin
          if (rif.timeout) begin
            scl_drive_low <= 1'b1;
            bit_cnt_reg   <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == 4'd8) begin
              state_reg     <= ST_IDLE;
            end else begin
              shift_reg     <= {shift_reg[6:0], 1'b1};
              // Ninth bit: release SDA for the slave's answer
              sda_drive_low <= bit_cnt_reg != 4'd7 && !shift_reg[6];
              state_reg     <= ST_TX_LOW;
            end
          end
        end
        ST_RX_HIGH: begin
          if (rif.timeout) begin
            // Shift SDA in at the falling edge
            scl_drive_low <= 1'b1;
            shift_reg     <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg   <= bit_cnt_reg + 4'd1;
            state_reg     <= (bit_cnt_reg == 4'd7) ? ST_IDLE : ST_RX_LOW;
          end
        end
        ST_ACK_HIGH: begin
          if (rif.timeout) begin
            scl_drive_low <= 1'b1;
            sda_drive_low <= 1'b0;
            state_reg     <= ST_IDLE;
          end
        end
        ST_STOP_SDA: begin
          if (!sda_s2) begin
            state_reg <= ST_STOP_LOW;
          end
        end
        ST_STOP_HIGH: begin
          // SDA released one period after SCL
          if (rif.timeout) begin
            sda_drive_low <= 1'b0;
            state_reg     <= ST_STOP_END;
          end
        end
        ST_STOP_END: begin
          if (rif.timeout) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // High phases wait for SCL really high, then reload
  always_comb begin
    rif.reload = rate_reload_reg;
    rif.run    = 1'b0;
    rif.load   = 1'b0;
    case (state_reg)
      ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW, ST_STOP_LOW: begin
        rif.run = 1'b1;
      end
      ST_TX_HIGH, ST_RX_HIGH, ST_ACK_HIGH, ST_STOP_HIGH: begin
        rif.run  = scl_seen_high;
        rif.load = !scl_seen_high;
      end
      ST_STOP_END: rif.run = 1'b1;
      default:     rif.load = 1'b1;
    endcase
    if (state_reg == ST_STOP_SDA || (rif.timeout && state_reg != ST_IDLE)) begin
      rif.load = 1'b1;
      rif.run  = 1'b0;
    end
  end

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_n || !port_en_reg) begin
      buffer_full         <= 1'b0;
      write_collision     <= 1'b0;
      receive_overflow    <= 1'b0;
      ack_received_status <= 1'b0;
      data_buffer_reg     <= 8'h00;
    end else begin
      if (wr_data && busy) begin
        write_collision <= 1'b1;
      end else if (wr && paddr == i2c_master_pkg::STATUS_OFF &&
                   !pwdata[i2c_master_pkg::WRITE_COLL_BIT]) begin
        write_collision <= 1'b0;
      end
      if (wr && paddr == i2c_master_pkg::STATUS_OFF &&
          !pwdata[i2c_master_pkg::RX_OVERFLOW_BIT] && !byte_done_rx) begin
        receive_overflow <= 1'b0;
      end
      if (byte_done_rx && buffer_full) begin
        receive_overflow <= 1'b1;
      end
      // Ack status from the ninth bit
      if (byte_done_tx) begin
        ack_received_status <= sda_s2;
      end
      if (collide) begin
        buffer_full <= 1'b0;
      end else if (wr_data && !busy) begin
        data_buffer_reg <= pwdata[7:0];
        buffer_full     <= 1'b1;
      end else if (state_reg == ST_TX_HIGH && rif.timeout &&
                   bit_cnt_reg == 4'd7) begin
        buffer_full <= 1'b0;
      end else if (byte_done_rx) begin
        data_buffer_reg <= {shift_reg[6:0], sda_s2};
        buffer_full     <= 1'b1;
      end else if (rd && paddr == i2c_master_pkg::DATA_BUFFER_OFF &&
                   rx_mode_reg) begin
        buffer_full <= 1'b0;
      end
    end
  end

  // Bus condition tracking and sticky event flags
  always_ff @(posedge clk) begin
    if (!rst_n || !port_en_reg) begin
      begin_detected  <= 1'b0;
      halt_detected   <= 1'b0;
      port_event_flag <= 1'b0;
      collision_flag  <= 1'b0;
    end else begin
      if (bus_start) begin
        begin_detected <= 1'b1;
        halt_detected  <= 1'b0;
      end else if (bus_stop) begin
        // Halt on SDA rise under SCL high
        halt_detected  <= 1'b1;
        begin_detected <= 1'b0;
      end
      if (wr_evt && !pwdata[i2c_master_pkg::PORT_EVENT_BIT]) begin
        port_event_flag <= 1'b0;
      end
      if (wr_evt && !pwdata[i2c_master_pkg::COLLISION_BIT]) begin
        collision_flag <= 1'b0;
      end
      // Byte done or stop sequence done event; stop seen after collision
      if (byte_done_rx || byte_done_tx || stop_done ||
          (collision_flag && bus_stop)) begin
        port_event_flag <= 1'b1;
      end
      if (collide) begin
        collision_flag <= 1'b1;
      end
    end
  end

  // Sticky flags request wake; completes in sleep
  assign wake_req = (port_event_flag && event_ie_reg) ||
                    (collision_flag && coll_ie_reg);

  // Open-drain pins: only ever drive low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_drive_low;
  assign sda_oe  = sda_drive_low;

  property p_coll_frees;
    @(posedge clk) disable iff (!rst_n)
      (collide && port_en_reg) |=> (!scl_oe && !sda_oe && !buffer_full &&
                                    collision_flag);
  endproperty
  a_coll_frees: assert property (p_coll_frees)
    else $error("collision did not free the lines");

  property p_write_collision;
    @(posedge clk) disable iff (!rst_n)
      (wr_data && busy && port_en_reg) |=>
        (write_collision && $stable(data_buffer_reg));
  endproperty
  a_write_collision: assert property (p_write_collision)
    else $error("busy write was not dropped");

  property p_rx_done;
    @(posedge clk) disable iff (!rst_n)
      (byte_done_rx && !collide && port_en_reg) |=>
        (buffer_full && port_event_flag && !receive_enable_bit && scl_oe);
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("reception end flags wrong");

  property p_tx_full;
    @(posedge clk) disable iff (!rst_n)
      (wr_data && !busy && port_en_reg && !collide) |=> buffer_full;
  endproperty
  a_tx_full: assert property (p_tx_full)
    else $error("buffer write did not set full");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      (port_event_flag && event_ie_reg) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("event flag not requesting wake");

  property p_hold_pause;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_TX_HIGH && !scl_seen_high) |-> !rif.timeout;
  endproperty
  a_hold_pause: assert property (p_hold_pause)
    else $error("counter ran while SCL held low");

  property p_ack_drive;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_ACK_LOW) |-> (scl_oe && sda_oe == !ack_value_bit);
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack sequence drive wrong");

  property p_stop_end;
    @(posedge clk) disable iff (!rst_n)
      (stop_done && !collide && port_en_reg) |=>
        (!stop_sequence_enable && port_event_flag);
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop completion flags wrong");
endmodule : i2c_master_engine

// [rtl/i2c_master_pkg.sv]
// Constants shared by the two-wire master engine
package i2c_master_pkg;
  // APB register byte offsets
  localparam logic [7:0] DATA_BUFFER_OFF  = 8'h00;
  localparam logic [7:0] STATUS_OFF       = 8'h04;
  localparam logic [7:0] CONTROL2_OFF     = 8'h08;
  localparam logic [7:0] RATE_RELOAD_OFF  = 8'h0C;
  localparam logic [7:0] EVENT_OFF        = 8'h10;
  // port_status_reg fields
  localparam int BUFFER_FULL_BIT   = 0;
  localparam int START_SEEN_BIT    = 3;
  localparam int HALT_DETECTED_BIT = 4;
  localparam int RX_OVERFLOW_BIT   = 5;
  localparam int WRITE_COLL_BIT    = 6;
  // control2_reg fields
  localparam int PORT_ENABLE_BIT   = 7;
  localparam int ACK_STATUS_BIT    = 6;
  localparam int ACK_VALUE_BIT     = 5;
  localparam int ACK_SEQ_BIT       = 4;
  localparam int RX_ENABLE_BIT     = 3;
  localparam int STOP_SEQ_BIT      = 2;
  // event register fields
  localparam int PORT_EVENT_BIT    = 0;
  localparam int COLLISION_BIT     = 1;
  localparam int EVENT_IE_BIT      = 2;
  localparam int COLLISION_IE_BIT  = 3;
  // Reset values
  localparam logic [6:0] RATE_RELOAD_RST = 7'h04;
  localparam logic [7:0] CONTROL2_RST    = 8'h00;
  // Counter width and bits per byte
  localparam int RATE_W   = 7;
  localparam int BYTE_BITS = 8;
  // Phases per instruction cycle (rate counter steps on two of the four)
  localparam int PHASES_PER_CYCLE = 4;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage : i2c_master_pkg

// [rtl/rate_counter.sv]
// Reloadable down counter stepping on the second and fourth phase
`timescale 1ns/1ns
module rate_counter (
  input  wire logic clk,
  input  wire logic rst_n,
  rate_if.counter   rif
);
  i2c_master_pkg::phase_t phase_reg;
  logic [6:0]             count_reg;
  logic                   step;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= i2c_master_pkg::PH_Q1;
    end else begin
      case (phase_reg)
        i2c_master_pkg::PH_Q1: phase_reg <= i2c_master_pkg::PH_Q2;
        i2c_master_pkg::PH_Q2: phase_reg <= i2c_master_pkg::PH_Q3;
        i2c_master_pkg::PH_Q3: phase_reg <= i2c_master_pkg::PH_Q4;
        default:               phase_reg <= i2c_master_pkg::PH_Q1;
      endcase
    end
  end

  assign step = (phase_reg == i2c_master_pkg::PH_Q2) ||
                (phase_reg == i2c_master_pkg::PH_Q4);

  // Load, count down, stop at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 7'h00;
    end else if (rif.load) begin
      count_reg <= rif.reload;
    end else if (rif.run && step && count_reg != 7'h00) begin
      count_reg <= count_reg - 7'h01;
    end
  end

  // Timeout is the bare zero count so that the engine may reload on it
  // without a combinational loop through run and load
  assign rif.timeout = (count_reg == 7'h00);

  property p_zero_holds;
    @(posedge clk) disable iff (!rst_n)
      (count_reg == 7'h00 && !rif.load) |=> (count_reg == 7'h00);
  endproperty
  a_zero_holds: assert property (p_zero_holds)
    else $error("rate counter left zero without reload");

  property p_step_phase;
    @(posedge clk) disable iff (!rst_n)
      (!rif.load && !step) |=> $stable(count_reg);
  endproperty
  a_step_phase: assert property (p_step_phase)
    else $error("rate counter stepped off phase");
endmodule : rate_counter

// [rtl/rate_if.sv]
// Handshake between the engine and its rate counter
`timescale 1ns/1ns
interface rate_if;
  logic       load;
  logic       run;
  logic [6:0] reload;
  logic       timeout;
  modport engine (output load, output run, output reload, input timeout);
  modport counter (input load, input run, input reload, output timeout);
endinterface : rate_if

// [tb/i2c_far_model.sv]
// Far-side slave: acknowledges, sends one byte, or jams SDA
`timescale 1ns/1ns
module i2c_far_model (
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       clr,
  input  wire logic       rx,
  input  wire logic       nack,
  input  wire logic       jam,
  input  wire logic [7:0] rx_byte,
  output logic      [7:0] seen,
  output logic            sda_oe
);
  logic [3:0] cnt;
  logic       scl_q, up;
  // A fall before the first rise is the opening pull-down, not a pulse
  always_ff @(posedge clk) begin
    scl_q <= scl;
    if (clr) begin
      cnt <= 4'h0;
      up  <= 1'b0;
    end else begin
      if (!scl_q && scl) up <= 1'b1;
      if (up && scl_q && !scl) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (clr) seen <= 8'h00;
    else if (!scl_q && scl && cnt < 4'h8) seen <= {seen[6:0], sda};
  end
  // Data changes only after a falling SCL so it is stable while high
  assign sda_oe = jam | (!clr & (rx ? (cnt < 4'h8 && !rx_byte[3'h7 - cnt[2:0]])
                                     : (cnt == 4'h8 && !nack)));
endmodule // i2c_far_model

// [tb/tb.sv]
// Self-checking bench of the two-wire master engine
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, rx_byte = 8'hC3, seen;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic clr = 1'b1, rx = 1'b0, nack = 1'b0, jam = 1'b0;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake_req, m_oe;
  int n_mismatch = 0, check_count = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe | m_oe);
  localparam logic [7:0] DB = i2c_master_pkg::DATA_BUFFER_OFF;
  localparam logic [7:0] ST = i2c_master_pkg::STATUS_OFF;
  localparam logic [7:0] C2 = i2c_master_pkg::CONTROL2_OFF;
  localparam logic [7:0] EV = i2c_master_pkg::EVENT_OFF;
  always #50 clk = !clk;
  i2c_master_engine dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wake_req(wake_req));
  i2c_far_model far_u (.clk(clk), .scl(scl), .sda(sda), .clr(clr), .rx(rx),
    .nack(nack), .jam(jam), .rx_byte(rx_byte), .seen(seen), .sda_oe(m_oe));
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic rb(input logic [7:0] a, input int b, input logic e);
    apb(1'b0, a, 32'h0);
    chk({31'h0, q[b]}, {31'h0, e});
  endtask
  // Bounded wait on a flag seen over the register bus
  task automatic poll(input logic [7:0] a, input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, a, 32'h0);
      if (q[b] === 1'b1) return;
    end
    n_mismatch++;
    finish_test();
  endtask
  task automatic tx_byte(input logic [7:0] d, input logic na, input logic e);
    clr <= 1'b0;
    nack <= na;
    apb(1'b1, DB, {24'h0, d});
    rb(ST, 0, 1'b1);
    apb(1'b1, DB, 32'h0000003C);
    rb(ST, 6, 1'b1);
    poll(EV, 0);
    chk({24'h0, seen}, {24'h0, d});
    rb(ST, 0, 1'b0);
    rb(C2, 6, e);
    chk({31'h0, wake_req}, 32'h1);
    apb(1'b1, ST, 32'h0);
    apb(1'b1, EV, 32'h0000000C);
    clr <= 1'b1;
    @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, C2, 32'h0);
    chk(q, {24'h0, i2c_master_pkg::CONTROL2_RST});
    apb(1'b0, i2c_master_pkg::RATE_RELOAD_OFF, 32'h0);
    chk(q, {25'h0, i2c_master_pkg::RATE_RELOAD_RST});
    apb(1'b1, C2, 32'h00000080);
    apb(1'b1, EV, 32'h0000000C);
    tx_byte(8'hA5, 1'b0, 1'b0);
    tx_byte(8'h5A, 1'b1, 1'b1);
    rx <= 1'b1;
    clr <= 1'b0;
    apb(1'b1, C2, 32'h00000088);
    poll(EV, 0);
    rb(C2, 3, 1'b0);
    rb(ST, 0, 1'b1);
    apb(1'b0, DB, 32'h0);
    chk(q, 32'h000000C3);
    rb(ST, 0, 1'b0);
    // ack value cleared before starting the sequence
    apb(1'b1, C2, 32'h00000090);
    repeat (100) @(posedge clk);
    rb(C2, 4, 1'b0);
    chk({31'h0, scl_oe}, 32'h1);
    clr <= 1'b1;
    rx <= 1'b0;
    apb(1'b1, EV, 32'h0000000C);
    apb(1'b1, C2, 32'h00000084);
    poll(EV, 0);
    rb(ST, 4, 1'b1);
    rb(C2, 2, 1'b0);
    apb(1'b1, EV, 32'h0000000C);
    // SDA jammed low before the write; the sent byte collides and frees the lines
    jam <= 1'b1;
    apb(1'b1, DB, 32'h000000FF);
    poll(EV, 1);
    rb(ST, 0, 1'b0);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    jam <= 1'b0;
    finish_test();
  end
endmodule // tb
